// ### src/plt_top.sv
//////////////////////////////////////////////////////////////////////////
// Purpose: led timing and interrupt pin control behind the phy registers
// Assumes: page selection is decoded upstream; inputs synchronous to clk
// Notes:   rst is the hardware reset; sw_reset leaves every field alone
// Contract
// R1 - force bit drives interrupt output asserted
// R2 - stretch code sets activity hold time
// R3 - polarity bit, loaded from strap on reset
// R4 - blink period code, strap selected default
// R5 - software writes zeros to reserved bits
// R6 - speed train on and off lengths
// R7 - intervals from ms prescaler, change at boundary
//////////////////////////////////////////////////////////////////////////
module plt_top
    import plt_pkg::*;
#(
    parameter int TICK_CYCLES = plt_pkg::TICK_CYC  // shorten in simulation
)(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   sw_reset,
    // configuration straps
    input  wire logic                   strap_interrupt_polarity,
    input  wire logic [1:0]             strap_led_configuration,
    // management port
    input  wire plt_pkg::plt_mgmt_req_t mgmt_req,
    output logic [15:0]                 mgmt_rdata,
    // events from the phy core
    input  wire logic                   irq_req,
    input  wire logic                   activity,
    input  wire logic                   speed_train_en,
    // indications
    output logic                        interrupt_output_pin,
    output logic                        led_activity,
    output logic                        led_blink,
    output logic                        led_speed
);
    import plt_pkg::*;

    // elaboration check: prescaler must fit its 16-bit counter
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_chk
        $error("TICK_CYCLES out of range");
    end

    localparam logic [15:0] PRE_LAST = 16'(TICK_CYCLES - 1);

    plt_top_st_t      st_reg;     // registered state
    plt_top_st_t      st_next;    // next state
    logic             blink_done; // blink half-period boundary
    logic             spd_done;   // speed phase boundary
    logic [CNT_W-1:0] blink_len;  // half period in ms
    logic [CNT_W-1:0] spd_len;    // length of the coming phase

    //////////////////////////////////////////////////////////////////////
    // decoders, speed decode used for both phases
    function automatic logic [CNT_W-1:0] speed_ms(input logic [1:0] c);
        unique case (c)
            2'h0:    speed_ms = 12'h054;   // 84 ms
            2'h1:    speed_ms = 12'h0AA;   // 170 ms
            2'h2:    speed_ms = 12'h154;   // 340 ms
            default: speed_ms = 12'h29E;   // 670 ms
        endcase
    endfunction

    // half of the blink period; reserved codes run at the slowest rate
    function automatic logic [CNT_W-1:0] blink_half(input logic [2:0] c);
        unique case (c)
            3'h0:    blink_half = 12'h015; // 42 ms period
            3'h1:    blink_half = 12'h02A; // 84 ms
            3'h2:    blink_half = 12'h055; // 170 ms
            3'h3:    blink_half = 12'h0AA; // 340 ms
            default: blink_half = 12'h14F; // 670 ms
        endcase
    endfunction

    assign blink_len = blink_half(st_reg.ctl.blink);                // R4
    // next phase flips, so load the length of the phase being entered
    assign spd_len   = st_reg.spd_ph ? speed_ms(st_reg.ctl.spd_off)
                                     : speed_ms(st_reg.ctl.spd_on); // R6

    //////////////////////////////////////////////////////////////////////
    // interval timers
    plt_interval u_blink (
        .clk    (clk),
        .rst    (rst),
        .tick   (st_reg.tick),
        .len_ms (blink_len),
        .done   (blink_done)
    );

    plt_interval u_speed (
        .clk    (clk),
        .rst    (rst),
        .tick   (st_reg.tick),
        .len_ms (spd_len),
        .done   (spd_done)
    );

    //////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        // free-running prescaler gives the ms enable
        if (st_reg.pre == PRE_LAST) begin
            st_next.pre  = '0;
            st_next.tick = 1'b1;                                     // R7
        end else begin
            st_next.pre = st_reg.pre + 16'h0001;
        end
        // register writes; reserved bits stored as written
        if (mgmt_req.wr && mgmt_req.addr == ADDR_TIMER) begin
            st_next.ctl = plt_ctl_t'(mgmt_req.wdata);                // R5
        end
        if (mgmt_req.wr && mgmt_req.addr == ADDR_UPPER) begin
            st_next.upper = mgmt_req.wdata;
        end
        // reads return zero off the map
        if (mgmt_req.rd) begin
            unique case (mgmt_req.addr)
                ADDR_TIMER: st_next.rdata = st_reg.ctl;
                ADDR_UPPER: st_next.rdata = st_reg.upper;
                default:    st_next.rdata = 16'h0000;
            endcase
        end
        // activity stretch; a new event restarts the hold
        if (st_reg.ctl.stretch == 3'h0) begin
            st_next.act     = activity;                              // R2
            st_next.str_cnt = '0;
        end else if (activity) begin
            st_next.str_cnt = STRETCH_BASE_MS << (st_reg.ctl.stretch - 3'h1);
            st_next.act     = 1'b1;                                  // R2
        end else if (st_reg.tick && st_reg.str_cnt != '0) begin
            st_next.str_cnt = st_reg.str_cnt - CNT_W'(1);
            st_next.act     = (st_reg.str_cnt != CNT_W'(1));
        end
        // blink toggles only at a boundary, so no runt pulses
        if (blink_done) begin
            st_next.blink = ~st_reg.blink;                           // R4
        end
        // speed train alternates on and off phases
        if (spd_done) begin
            st_next.spd_ph = ~st_reg.spd_ph;                         // R6
        end
        st_next.spd = st_next.spd_ph & speed_train_en;
        // interrupt pin: force or request, then polarity
        st_next.intp = (st_reg.ctl.force_int | irq_req)
                       ^ st_reg.ctl.int_pol;                         // R1 R3
    end

    //////////////////////////////////////////////////////////////////////
    // state register; straps are sampled while hardware reset is held
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg               <= '0;
            st_reg.ctl.force_int <= FORCE_RST;                       // R1
            st_reg.ctl.stretch   <= STRETCH_RST;                     // R2
            st_reg.ctl.int_pol   <= strap_interrupt_polarity;        // R3
            st_reg.ctl.blink     <= (strap_led_configuration == LED_STRAP_FAST)
                                    ? BLINK_FAST : BLINK_SLOW;       // R4
            st_reg.ctl.rsvd      <= RSVD_RST;
            st_reg.ctl.spd_off   <= SPEED_RST;                       // R6
            st_reg.ctl.spd_on    <= SPEED_RST;                       // R6
            st_reg.upper         <= UPPER_RST;
            st_reg.intp          <= strap_interrupt_polarity;        // idle
        end else begin
            // sw_reset keeps all values, so it is ignored here
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign mgmt_rdata           = st_reg.rdata;
    assign interrupt_output_pin = st_reg.intp;
    assign led_activity         = st_reg.act;
    assign led_blink            = st_reg.blink;
    assign led_speed            = st_reg.spd;

    //////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_force_int;
        st_reg.ctl.force_int
            |=> interrupt_output_pin == !$past(st_reg.ctl.int_pol);
    endproperty
    a_force_int: assert property (p_force_int) // R1
        else $error("forced interrupt not asserted");

    property p_stretch_hold;
        (activity && st_reg.ctl.stretch == 3'h4 && !mgmt_req.wr)
            |=> led_activity [*8];
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) // R2
        else $error("stretched activity dropped early");

    property p_no_stretch;
        (st_reg.ctl.stretch == 3'h0) |=> led_activity == $past(activity);
    endproperty
    a_no_stretch: assert property (p_no_stretch) // R2
        else $error("activity stretched with code zero");

    // reset values are looked at on the first edge after release, since
    // the default disable would swallow any attempt made while rst is high
    property p_pol_strap;
        $fell(rst) |-> st_reg.ctl.int_pol == $past(strap_interrupt_polarity);
    endproperty
    a_pol_strap: assert property (p_pol_strap) // R3
        else $error("polarity not loaded from strap");

    property p_blink_strap;
        $fell(rst) |-> st_reg.ctl.blink ==
            (($past(strap_led_configuration) == 2'h1) ? 3'h0 : 3'h1);
    endproperty
    a_blink_strap: assert property (p_blink_strap) // R4
        else $error("blink default wrong for strap");

    property p_speed_reset;
        $fell(rst) |-> st_reg.ctl.spd_on == 2'h1
            && st_reg.ctl.spd_off == 2'h1 && st_reg.ctl.stretch == 3'h4;
    endproperty
    a_speed_reset: assert property (p_speed_reset) // R6
        else $error("timing fields reset wrong");

    property p_tick_spacing;
        st_reg.tick |=> !st_reg.tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // R7
        else $error("ms enable wider than one cycle");

    property p_blink_boundary;
        $changed(led_blink) |-> $past(blink_done);
    endproperty
    a_blink_boundary: assert property (p_blink_boundary) // R7
        else $error("blink changed off a boundary");
endmodule

// ### src/plt_pkg.sv
// Purpose: shared constants and carriers for the led timer control block
// Assumes: 20 MHz system clock, 16-bit management registers
// Notes:   register 0x12 fields match plt_ctl_t bit for bit
package plt_pkg;

    // clock and prescaler timing
    localparam int CLK_MHZ       = 20;            // system clock rate
    localparam int TICK_US       = 1000;          // led time base, 1 ms
    localparam int TICK_CYC      = TICK_US * CLK_MHZ; // cycles per tick

    // register addresses on the management port
    localparam logic [4:0] ADDR_TIMER = 5'h12;    // timing and interrupt
    localparam logic [4:0] ADDR_UPPER = 5'h13;    // upper pair function

    // reset values
    localparam logic       FORCE_RST   = 1'h0;
    localparam logic [2:0] STRETCH_RST = 3'h4;
    localparam logic [3:0] RSVD_RST    = 4'h0;
    localparam logic [1:0] SPEED_RST   = 2'h1;
    localparam logic [2:0] BLINK_FAST  = 3'h0;    // led strap 01b
    localparam logic [2:0] BLINK_SLOW  = 3'h1;    // every other strap
    localparam logic [1:0] LED_STRAP_FAST = 2'h1;
    localparam logic [15:0] UPPER_RST  = 16'h0000;

    // stretch base interval in ms, doubled per code step
    localparam logic [11:0] STRETCH_BASE_MS = 12'h015; // 21 ms
    localparam int          CNT_W = 12;           // ms counter width

    // fields of the timing and interrupt register, msb first
    typedef struct packed {
        logic       force_int;                    // bit 15
        logic [2:0] stretch;                      // 14:12
        logic       int_pol;                      // 11, 1 = active low
        logic [2:0] blink;                        // 10:8
        logic [3:0] rsvd;                         // 7:4
        logic [1:0] spd_off;                      // 3:2
        logic [1:0] spd_on;                       // 1:0
    } plt_ctl_t;

    // management port request
    typedef struct packed {
        logic        wr;                          // write strobe
        logic        rd;                          // read strobe
        logic [4:0]  addr;                        // register number
        logic [15:0] wdata;                       // write data
    } plt_mgmt_req_t;

    // whole state of the top module
    typedef struct packed {
        plt_ctl_t           ctl;                  // register 0x12
        logic [15:0]        upper;                // register 0x13
        logic [15:0]        rdata;                // read data
        logic [15:0]        pre;                  // prescaler count
        logic               tick;                 // 1 ms enable
        logic [CNT_W-1:0]   str_cnt;              // stretch remaining
        logic               act;                  // stretched activity
        logic               blink;                // blink square wave
        logic               spd_ph;               // 1 = on phase
        logic               spd;                  // speed pulse train
        logic               intp;                 // interrupt pin level
    } plt_top_st_t;

    // state of the interval timer
    typedef struct packed {
        logic [CNT_W-1:0] cnt;                    // ticks left
        logic             done;                   // boundary pulse
    } plt_ivl_st_t;

endpackage

// ### src/plt_interval.sv
// Purpose: interval timer counting ms ticks, pulses at each boundary
// Assumes: tick is a one-cycle enable
// Notes:   length is sampled only at a boundary, so changes never cut
//          an interval short
module plt_interval
    import plt_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // timing
    input  wire logic                       tick,
    input  wire logic [plt_pkg::CNT_W-1:0]  len_ms,
    // boundary
    output logic                            done
);
    plt_ivl_st_t st_reg;   // registered state
    plt_ivl_st_t st_next;  // next state

    // count down, reload at one (or zero after reset)
    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (tick) begin
            if (st_reg.cnt <= CNT_W'(1)) begin
                st_next.cnt  = len_ms;                       // R7
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - CNT_W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = st_reg.done;
endmodule

// ### bench/plt_mgmt_model.sv
// Purpose: station management controller model on the register port
// Assumes: one-cycle strobes, read data settles one edge after the strobe
// Notes:   idle address and data lines show a changing pattern, never the
//          last value, so a design that samples them late is caught
module plt_mgmt_model
    import plt_pkg::*;
(
    // clock
    input  wire logic                   clk,
    // management port
    output plt_pkg::plt_mgmt_req_t      req,
    input  wire logic [15:0]            rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // start idle with no strobe
    initial begin
        req = '0;
    end

    ////////////////////////////////////////////////////////////////////
    // one write: strobe for a single edge, reserved bits sent as zero
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] w;
        w = d;
        if (a === ADDR_TIMER) w[7:4] = 4'h0;
        if (a === ADDR_UPPER) w[15:12] = 4'h0;
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
    endtask

    // one read: data taken once the answer edge has passed
    task automatic read(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hA5C3};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h5A3C};
        @(posedge clk);
        #1 d = rdata;
    endtask
endmodule

// ### bench/plt_top_test.sv
// Purpose: self-checking bench for the led timer and interrupt block
// Assumes: prescaler shortened to 4 cycles per ms
// Notes:   interval lengths are checked with a one-tick tolerance
module plt_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import plt_pkg::*;

    localparam int TK = 4;                  // cycles per ms in this run

    // design connections
    logic          clk, rst, sw_reset, s_pol, irq_req, activity, spd_en;
    logic [1:0]    s_led;
    plt_mgmt_req_t req;
    logic [15:0]   rdata, rd;
    logic          pin, l_act, l_blink, l_spd;
    int            mismatches, n_tests, n;

    // row: register write, expected read back, irq level, pin level
    typedef struct packed {
        logic [4:0] a; logic [15:0] w; logic [15:0] r;
        logic irq; logic pin;
    } plt_row_t;
    plt_row_t rows [8] = '{
        '{5'h12, 16'h0105, 16'h0105, 1'b0, 1'b0},
        '{5'h12, 16'h0105, 16'h0105, 1'b1, 1'b1},
        '{5'h12, 16'h0905, 16'h0905, 1'b1, 1'b0},
        '{5'h12, 16'h0905, 16'h0905, 1'b0, 1'b1},
        '{5'h12, 16'h8905, 16'h8905, 1'b0, 1'b0},
        '{5'h12, 16'h81F5, 16'h8105, 1'b0, 1'b1},
        '{5'h13, 16'hFABC, 16'h0ABC, 1'b0, 1'b1},
        '{5'h05, 16'hFFFF, 16'h0000, 1'b0, 1'b1}
    };

    plt_top #(.TICK_CYCLES(TK)) DUT (
        .clk(clk), .rst(rst), .sw_reset(sw_reset),
        .strap_interrupt_polarity(s_pol), .strap_led_configuration(s_led),
        .mgmt_req(req), .mgmt_rdata(rdata), .irq_req(irq_req),
        .activity(activity), .speed_train_en(spd_en),
        .interrupt_output_pin(pin), .led_activity(l_act),
        .led_blink(l_blink), .led_speed(l_spd));

    plt_mgmt_model mgmt (.clk(clk), .req(req), .rdata(rdata));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // current level of one indication: 0 activity, 1 blink, 2 speed
    function automatic logic cur(input int s);
        return (s == 0) ? l_act : (s == 1) ? l_blink : l_spd;
    endfunction

    // cycles until the chosen indication changes, bounded
    task automatic wait_chg(input int s, output int cnt);
        logic v;
        v = cur(s);
        for (cnt = 1; cnt < 4000; cnt++) begin
            @(posedge clk);
            #1;
            if (cur(s) !== v) return;
        end
        chk("indication change", {15'h0, cur(s)}, {15'h0, ~v});
        end_of_test();
    endtask

    // hardware reset with a given pair of straps, held 20 cycles
    task automatic hw_reset(input logic p, input logic [1:0] l);
        @(posedge clk);
        rst <= 1'b1;
        s_pol <= p;
        s_led <= l;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; sw_reset = 1'b0; s_pol = 1'b0; s_led = 2'h0;
        irq_req = 1'b0; activity = 1'b0; spd_en = 1'b0;
        mismatches = 0; n_tests = 0;

        // reset values for two strap settings, second one in mid-run
        hw_reset(1'b1, 2'h1);
        // one activity event under the reset stretch code
        activity <= 1'b1;
        @(posedge clk);
        activity <= 1'b0;
        mgmt.read(ADDR_TIMER, rd);
        chk("timer reset", rd, 16'h4805);
        chk("pin idle", {15'h0, pin}, 16'h0001);
        chk("act held", {15'h0, l_act}, 16'h0001);
        mgmt.read(ADDR_UPPER, rd);
        chk("upper reset", rd, UPPER_RST);
        hw_reset(1'b0, 2'h0);
        mgmt.read(ADDR_TIMER, rd);
        chk("timer reset 2", rd, 16'h4105);
        $display("reset test done");

        // register rows with interrupt force and polarity
        foreach (rows[i]) begin
            @(posedge clk);
            irq_req <= rows[i].irq;
            mgmt.write(rows[i].a, rows[i].w);
            mgmt.read(rows[i].a, rd);
            chk("row read", rd, rows[i].r);
            chk("row pin", {15'h0, pin}, {15'h0, rows[i].pin});
        end
        $display("row test done");

        // software reset keeps the fields
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        mgmt.read(ADDR_TIMER, rd);
        chk("after sw reset", rd, 16'h8105);
        $display("software reset test done");

        // stretch off: led follows activity; code 1: about 21 ms hold
        mgmt.write(ADDR_TIMER, 16'h0005);
        @(posedge clk);
        activity <= 1'b1;
        wait_chg(0, n);
        @(posedge clk);
        activity <= 1'b0;
        chk("no stretch", n[15:0], 16'h0001);
        mgmt.write(ADDR_TIMER, 16'h1005);
        @(posedge clk);
        activity <= 1'b1;
        @(posedge clk);
        activity <= 1'b0;
        wait_chg(0, n);
        wait_chg(0, n);
        chk("stretch 21", {15'h0, n >= 20*TK && n <= 22*TK}, 16'h1);
        $display("stretch test done");

        // blink code 0 then 4: half periods 21 and 335 ms
        wait_chg(1, n);
        wait_chg(1, n);
        chk("blink 42", {15'h0, n >= 20*TK && n <= 22*TK}, 16'h1);
        mgmt.write(ADDR_TIMER, 16'h1405);
        wait_chg(1, n);
        wait_chg(1, n);
        wait_chg(1, n);
        chk("blink 670", {15'h0, n >= 334*TK && n <= 336*TK}, 16'h1);
        $display("blink test done");

        // speed train with on 84 ms and off 670 ms; the count starts on a
        // falling edge, so the off phase is measured first
        mgmt.write(ADDR_TIMER, 16'h100C);
        @(posedge clk);
        spd_en <= 1'b1;
        repeat (3) wait_chg(2, n);
        if (l_spd === 1'b1) wait_chg(2, n);
        wait_chg(2, n);
        chk("speed off", {15'h0, n >= 669*TK && n <= 671*TK}, 16'h1);
        wait_chg(2, n);
        chk("speed on", {15'h0, n >= 83*TK && n <= 85*TK}, 16'h1);
        $display("speed test done");
        end_of_test();
    end
endmodule
